// file: src/fmr_regs.v
// monitor readback register bank with AHB-Lite slave and producer update port
//
// How it works
// - phase B voltage from initial speed detection is read at index 0x480, V = w*60/(sqrt3*2^27).
// - phase C voltage from initial speed detection is read at index 0x482, same scaling as B.
// - sine of the commutation angle is read at index 0x4ba as a fraction where 2^27 is one.
// - cosine of the commutation angle is read at index 0x4bc as a fraction where 2^27 is one.
// - alpha-axis current is read at index 0x4d4, amperes = w/2^27*1.25.
// - beta-axis current is read at index 0x4d6, amperes = w/2^27*1.25.
// - every monitor word reads zero after reset until the producer writes it.
`timescale 1ns/10ps
`include "fmr_map.vh"

module fmr_regs #(
   parameter ADDR_W = 16,
   parameter CNT_W = 16
) (
   input wire core_clk,
   input wire rst_n,
   input wire hsel,
   input wire [ADDR_W-1:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output wire hreadyout,
   output wire hresp,
   input wire upd_valid,
   input wire [2:0] upd_index,
   input wire [31:0] upd_data
);

   // ---------------------------------------------------------------------------
   // decoding helpers
   // ---------------------------------------------------------------------------
   // one-hot hit on the six monitor words for a word index
   function [5:0] word_hit;
      input [11:0] idx;
      begin
         word_hit = 6'h00;
         if (idx == `FMR_IDX_PHASE_B) begin
            word_hit = 6'h01;
         end else if (idx == `FMR_IDX_PHASE_C) begin
            word_hit = 6'h02;
         end else if (idx == `FMR_IDX_COMM_SIN) begin
            word_hit = 6'h04;
         end else if (idx == `FMR_IDX_COMM_COS) begin
            word_hit = 6'h08;
         end else if (idx == `FMR_IDX_I_ALPHA) begin
            word_hit = 6'h10;
         end else if (idx == `FMR_IDX_I_BETA) begin
            word_hit = 6'h20;
         end
      end
   endfunction

   // one-hot select of the producer target, codes 6 and 7 select nothing
   function [5:0] sel_hit;
      input [2:0] sel;
      begin
         sel_hit = 6'h00;
         if (sel == `FMR_SEL_PHASE_B) begin
            sel_hit = 6'h01;
         end else if (sel == `FMR_SEL_PHASE_C) begin
            sel_hit = 6'h02;
         end else if (sel == `FMR_SEL_COMM_SIN) begin
            sel_hit = 6'h04;
         end else if (sel == `FMR_SEL_COMM_COS) begin
            sel_hit = 6'h08;
         end else if (sel == `FMR_SEL_I_ALPHA) begin
            sel_hit = 6'h10;
         end else if (sel == `FMR_SEL_I_BETA) begin
            sel_hit = 6'h20;
         end
      end
   endfunction

   // ---------------------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------------------
   wire [11:0] addr_idx;
   wire addr_phase_ok;
   wire rd_accept;
   wire wr_accept;
   wire [5:0] rd_hit;
   wire [5:0] load_en;
   wire [5:0] fresh_set;
   wire [31:0] live_bus [0:5];
   wire [31:0] shown_bus [0:5];
   wire ctrl_wr;
   wire snap_pulse;
   wire clr_pulse;
   reg wr_pend_reg;
   reg [11:0] wr_idx_reg;
   reg live_mode_reg;
   reg [5:0] fresh_reg;
   reg [5:0] fresh_next;
   reg [5:0] ovr_reg;
   reg [5:0] ovr_next;
   reg [CNT_W-1:0] upd_cnt_reg;
   reg [CNT_W-1:0] upd_cnt_next;
   reg [31:0] rd_next;
   integer k;

   // ---------------------------------------------------------------------------
   // bus address phase
   // ---------------------------------------------------------------------------
   // the slave never stalls and never errors, every transfer ends in one data cycle
   assign hreadyout = 1'b1;
   assign hresp = `FMR_HRESP_OKAY;
   assign addr_idx = haddr[13:2];
   assign addr_phase_ok = hsel && hready && (htrans == `FMR_HTRANS_NONSEQ);
   assign rd_accept = addr_phase_ok && !hwrite;
   // only whole-word writes are taken; narrower ones are dropped quietly
   assign wr_accept = addr_phase_ok && hwrite && (hsize == `FMR_HSIZE_WORD);
   assign rd_hit = rd_accept ? word_hit(addr_idx) : 6'h00;

   // write address is held for the following data phase
   always @(posedge core_clk) begin
      if (!rst_n) begin
         wr_pend_reg <= 1'b0;
         wr_idx_reg <= 12'h000;
      end else begin
         wr_pend_reg <= wr_accept;
         if (wr_accept) begin
            wr_idx_reg <= addr_idx;
         end
      end
   end

   // ---------------------------------------------------------------------------
   // control register
   // ---------------------------------------------------------------------------
   // writes to the monitor words match no decode here and so change nothing
   assign ctrl_wr = wr_pend_reg && (wr_idx_reg == `FMR_IDX_CTRL);
   assign snap_pulse = ctrl_wr && hwdata[`FMR_CTRL_SNAP_BIT];
   assign clr_pulse = ctrl_wr && hwdata[`FMR_CTRL_CLR_BIT];

   // live mode bit: set, host copies follow the producer; clear, they hold
   always @(posedge core_clk) begin
      if (!rst_n) begin
         live_mode_reg <= `FMR_CTRL_LIVE_RST;
      end else if (ctrl_wr) begin
         live_mode_reg <= hwdata[`FMR_CTRL_LIVE_BIT];
      end
   end

   // ---------------------------------------------------------------------------
   // monitor words
   // ---------------------------------------------------------------------------
   // the producer writes one word per cycle; the bus has no path into them
   assign load_en = upd_valid ? sel_hit(upd_index) : 6'h00;

   genvar g;
   generate
      for (g = 0; g < `FMR_NUM_WORDS; g = g + 1) begin : gen_word
         fmr_word_latch #(
            .WIDTH(32)
         ) u_word (
            .core_clk(core_clk),
            .rst_n(rst_n),
            .load_en(load_en[g]),
            .load_data(upd_data),
            .live_mode(live_mode_reg),
            .snap(snap_pulse),
            .live_reg(live_bus[g]),
            .shown_reg(shown_bus[g])
         );
         // a host copy is fresh when it changes, by live load or snapshot
         assign fresh_set[g] = (live_mode_reg && load_en[g]) || snap_pulse;
      end
   endgenerate

   // ---------------------------------------------------------------------------
   // fresh and overrun flags, update counter
   // ---------------------------------------------------------------------------
   // fresh clears when the host reads the word; a new value in that cycle wins
   // overrun marks a fresh value replaced before the host read it
   always @* begin
      fresh_next = (fresh_reg & ~rd_hit) | fresh_set;
      ovr_next = ovr_reg | (fresh_reg & ~rd_hit & fresh_set);
      if (clr_pulse) begin
         ovr_next = fresh_reg & ~rd_hit & fresh_set;
      end
      upd_cnt_next = upd_cnt_reg;
      if (clr_pulse) begin
         upd_cnt_next = {CNT_W{1'b0}};
      end
      // an update in the clearing cycle is still counted
      if (|load_en) begin
         upd_cnt_next = upd_cnt_next + {{(CNT_W-1){1'b0}}, 1'b1};
      end
   end

   always @(posedge core_clk) begin
      if (!rst_n) begin
         fresh_reg <= 6'h00;
         ovr_reg <= 6'h00;
         upd_cnt_reg <= {CNT_W{1'b0}};
      end else begin
         fresh_reg <= fresh_next;
         ovr_reg <= ovr_next;
         upd_cnt_reg <= upd_cnt_next;
      end
   end

   // ---------------------------------------------------------------------------
   // read data
   // ---------------------------------------------------------------------------
   // sampled at the address-phase edge so data stands through the data phase;
   // the mux reads whole registered words, never a word mid-change
   always @* begin
      rd_next = 32'h0000_0000;
      for (k = 0; k < `FMR_NUM_WORDS; k = k + 1) begin
         if (rd_hit[k]) begin
            rd_next = shown_bus[k];
         end
      end
      if (addr_idx == `FMR_IDX_CTRL) begin
         rd_next[`FMR_CTRL_LIVE_BIT] = live_mode_reg;
      end else if (addr_idx == `FMR_IDX_STATUS) begin
         rd_next[`FMR_STAT_FRESH_LSB+5:`FMR_STAT_FRESH_LSB] = fresh_reg;
         rd_next[`FMR_STAT_OVR_LSB+5:`FMR_STAT_OVR_LSB] = ovr_reg;
         rd_next[`FMR_STAT_LIVE_BIT] = live_mode_reg;
      end else if (addr_idx == `FMR_IDX_UPD_COUNT) begin
         rd_next[CNT_W-1:0] = upd_cnt_reg;
      end
   end

   // reads of unmapped indices return zero
   always @(posedge core_clk) begin
      if (!rst_n) begin
         hrdata <= 32'h0000_0000;
      end else if (rd_accept) begin
         hrdata <= rd_next;
      end
   end

endmodule

// file: include/fmr_map.vh
// register map, field positions and reset values of the monitor readback bank
`ifndef FMR_MAP_VH
`define FMR_MAP_VH

// ----------------------------------------------------------------------------
// word indices (byte address = index * 4)
// ----------------------------------------------------------------------------
`define FMR_IDX_PHASE_B 12'h480
`define FMR_IDX_PHASE_C 12'h482
`define FMR_IDX_COMM_SIN 12'h4ba
`define FMR_IDX_COMM_COS 12'h4bc
`define FMR_IDX_I_ALPHA 12'h4d4
`define FMR_IDX_I_BETA 12'h4d6
`define FMR_IDX_CTRL 12'h500
`define FMR_IDX_STATUS 12'h501
`define FMR_IDX_UPD_COUNT 12'h502

// ----------------------------------------------------------------------------
// producer word select codes
// ----------------------------------------------------------------------------
`define FMR_SEL_PHASE_B 3'h0
`define FMR_SEL_PHASE_C 3'h1
`define FMR_SEL_COMM_SIN 3'h2
`define FMR_SEL_COMM_COS 3'h3
`define FMR_SEL_I_ALPHA 3'h4
`define FMR_SEL_I_BETA 3'h5
`define FMR_NUM_WORDS 6

// ----------------------------------------------------------------------------
// control and status fields
// ----------------------------------------------------------------------------
`define FMR_CTRL_LIVE_BIT 0
`define FMR_CTRL_SNAP_BIT 1
`define FMR_CTRL_CLR_BIT 2
`define FMR_STAT_FRESH_LSB 0
`define FMR_STAT_OVR_LSB 8
`define FMR_STAT_LIVE_BIT 16

// ----------------------------------------------------------------------------
// reset values and bus codes
// ----------------------------------------------------------------------------
`define FMR_WORD_RST 32'h0000_0000
`define FMR_CTRL_LIVE_RST 1'b1
`define FMR_HTRANS_NONSEQ 2'h2
`define FMR_HSIZE_WORD 3'h2
`define FMR_HRESP_OKAY 1'b0

`endif

// file: src/fmr_word_latch.v
// one monitor word: live copy from the producer and the copy shown to the host
`timescale 1ns/10ps
`include "fmr_map.vh"

module fmr_word_latch #(
   parameter WIDTH = 32
) (
   input wire core_clk,
   input wire rst_n,
   input wire load_en,
   input wire [WIDTH-1:0] load_data,
   input wire live_mode,
   input wire snap,
   output reg [WIDTH-1:0] live_reg,
   output reg [WIDTH-1:0] shown_reg
);

   // ---------------------------------------------------------------------------
   // storage
   // ---------------------------------------------------------------------------
   // whole word moves in one edge, so a host read never sees half old, half new
   always @(posedge core_clk) begin
      if (!rst_n) begin
         live_reg <= `FMR_WORD_RST;
         shown_reg <= `FMR_WORD_RST;
      end else begin
         if (load_en) begin
            live_reg <= load_data;
         end
         // in live mode the host copy follows the producer directly
         if (live_mode && load_en) begin
            shown_reg <= load_data;
         end else if (snap) begin
            // snapshot takes the pre-update live value: all words from one instant
            shown_reg <= live_reg;
         end
      end
   end

endmodule

// file: dv/fmr_regs_sva.sv
// checker: port assertions for the monitor readback bank
`timescale 1ns/10ps
`include "fmr_map.vh"
module fmr_regs_sva #(
   parameter ADDR_W = 16,
   parameter CNT_W = 16
) (
   input wire core_clk,
   input wire rst_n,
   input wire hsel,
   input wire [ADDR_W-1:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   input wire [31:0] hrdata,
   input wire hreadyout,
   input wire hresp,
   input wire upd_valid,
   input wire [2:0] upd_index,
   input wire [31:0] upd_data
);
   // ------------------------------------------------------------------
   // helper state
   // ------------------------------------------------------------------
   wire take = hsel && hready && (htrans == `FMR_HTRANS_NONSEQ);
   wire [11:0] ix = haddr[13:2];
   reg ctrl_seen_reg;
   reg [5:0] upd_seen_reg;
   // a control write may select hold mode, so live loads are only judged before one
   always @(posedge core_clk) begin
      if (!rst_n) begin
         ctrl_seen_reg <= 1'b0;
         upd_seen_reg <= 6'h00;
      end else begin
         if (take && hwrite && ix == `FMR_IDX_CTRL)
            ctrl_seen_reg <= 1'b1;
         if (upd_valid && upd_index < 3'h6)
            upd_seen_reg[upd_index] <= 1'b1;
      end
   end
   // ------------------------------------------------------------------
   // properties
   // ------------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   sequence s_upd(sel); upd_valid && upd_index == sel && !ctrl_seen_reg; endsequence
   sequence s_rd(idx); take && !hwrite && ix == idx; endsequence
   // the two quiet cycles keep a second load from muddying the expected word
   property p_load_read(sel, idx);
      s_upd(sel) ##1 !(upd_valid && upd_index == sel) [*2] ##1 s_rd(idx)
         |=> hrdata == $past(upd_data, 4);
   endproperty
   a_phase_b_read: assert property (p_load_read(`FMR_SEL_PHASE_B, `FMR_IDX_PHASE_B))
      else $error("phase b word differs from last load");
   a_phase_c_read: assert property (p_load_read(`FMR_SEL_PHASE_C, `FMR_IDX_PHASE_C))
      else $error("phase c word differs from last load");
   a_sine_read: assert property (p_load_read(`FMR_SEL_COMM_SIN, `FMR_IDX_COMM_SIN))
      else $error("sine word differs from last load");
   a_cosine_read: assert property (p_load_read(`FMR_SEL_COMM_COS, `FMR_IDX_COMM_COS))
      else $error("cosine word differs from last load");
   a_alpha_read: assert property (p_load_read(`FMR_SEL_I_ALPHA, `FMR_IDX_I_ALPHA))
      else $error("alpha word differs from last load");
   a_beta_read: assert property (p_load_read(`FMR_SEL_I_BETA, `FMR_IDX_I_BETA))
      else $error("beta word differs from last load");
   a_alpha_reset_zero: assert property ((take && !hwrite && ix == `FMR_IDX_I_ALPHA
      && !upd_seen_reg[4]) |=> hrdata == `FMR_WORD_RST) else $error("alpha word not zero");
   a_read_data_holds: assert property (!(take && !hwrite) |=> $stable(hrdata))
      else $error("read data moved without a read");
   a_bus_okay: assert property (hreadyout && hresp == `FMR_HRESP_OKAY)
      else $error("bus answer not ready and okay");
endmodule

bind fmr_regs fmr_regs_sva #(.ADDR_W(ADDR_W), .CNT_W(CNT_W)) i_sva (
   .core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .upd_valid(upd_valid), .upd_index(upd_index),
   .upd_data(upd_data)
);

// file: dv/tb_top.sv
// testbench: producer loads and bus reads of the monitor readback bank
`timescale 1ns/10ps
`include "fmr_map.vh"
module tb_top;
   typedef struct {logic [2:0] sel; logic [11:0] idx; logic [31:0] val;} fmr_row_t;
   reg core_clk, rst_n, hsel, hwrite, upd_valid;
   reg [15:0] haddr;
   reg [1:0] htrans;
   reg [2:0] hsize, upd_index;
   reg [31:0] hwdata, upd_data, rd;
   wire hready, hreadyout, hresp;
   wire [31:0] hrdata;
   integer failures, total_checks, i;
   fmr_row_t rows [0:5];
   // one slave on the bus, so its ready is the bus ready
   assign hready = hreadyout;
   fmr_regs i_dut (.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .upd_valid(upd_valid),
      .upd_index(upd_index), .upd_data(upd_data));
   // ------------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------------
   task conclude;
      begin
         $display("checks %0d mismatches %0d", total_checks, failures);
         if (failures == 0 && total_checks > 0)
            $display("== PASSED ==");
         else
            $display("== FAILED ==");
         $finish;
      end
   endtask
   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      begin
         total_checks = total_checks + 1;
         if (seen !== exp) begin
            failures = failures + 1;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
         end
      end
   endtask
   // bounded wait for ready at a rising edge; a hang ends the run
   task wait_rdy;
      integer n;
      begin
         n = 0;
         @(posedge core_clk);
         while (hreadyout !== 1'b1) begin
            n = n + 1;
            if (n > 32) begin
               failures = failures + 1;
               conclude();
            end
            @(posedge core_clk);
         end
      end
   endtask
   // one single word transfer: address phase, then data phase
   task ahb(input logic wr, input logic [15:0] a, input logic [31:0] wd);
      begin
         @(posedge core_clk);
         hsel <= 1'b1;
         htrans <= `FMR_HTRANS_NONSEQ;
         haddr <= a;
         hwrite <= wr;
         wait_rdy();
         htrans <= 2'h0;
         hwdata <= wd;
         wait_rdy();
         rd = hrdata;
      end
   endtask
   task upd(input logic [2:0] s, input logic [31:0] d);
      begin
         @(posedge core_clk);
         upd_valid <= 1'b1;
         upd_index <= s;
         upd_data <= d;
         @(posedge core_clk);
         upd_valid <= 1'b0;
      end
   endtask
   // reset is held long so a mid-run reset is seen as clearly as the first
   task do_reset;
      begin
         rst_n <= 1'b0;
         repeat (16) @(posedge core_clk);
         rst_n <= 1'b1;
         @(posedge core_clk);
      end
   endtask
   task read_zeros;
      for (i = 0; i < 6; i = i + 1) begin
         ahb(1'b0, {2'b00, rows[i].idx, 2'b00}, 32'h0);
         check("reset word", rd, `FMR_WORD_RST);
      end
   endtask
   // ------------------------------------------------------------------
   // clock and main sequence
   // ------------------------------------------------------------------
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   initial begin
      failures = 0;
      total_checks = 0;
      {rst_n, hsel, hwrite, upd_valid, haddr, htrans, hwdata, upd_index, upd_data} = 0;
      hsize = `FMR_HSIZE_WORD;
      // extremes of the fixed-point range for phase B and C, plus plus and minus one for the angle words, one LSB and a pattern for the currents
      rows[0] = '{`FMR_SEL_PHASE_B, `FMR_IDX_PHASE_B, 32'h7fff_ffff};
      rows[1] = '{`FMR_SEL_PHASE_C, `FMR_IDX_PHASE_C, 32'h8000_0000};
      rows[2] = '{`FMR_SEL_COMM_SIN, `FMR_IDX_COMM_SIN, 32'h0800_0000};
      rows[3] = '{`FMR_SEL_COMM_COS, `FMR_IDX_COMM_COS, 32'hf800_0000};
      rows[4] = '{`FMR_SEL_I_ALPHA, `FMR_IDX_I_ALPHA, 32'h0000_0001};
      rows[5] = '{`FMR_SEL_I_BETA, `FMR_IDX_I_BETA, 32'ha5a5_5a5a};
      do_reset();
      read_zeros();
      for (i = 0; i < 6; i = i + 1) begin
         upd(rows[i].sel, rows[i].val);
         ahb(1'b0, {2'b00, rows[i].idx, 2'b00}, 32'h0);
         check("monitor word", rd, rows[i].val);
      end
      // host writes, an unmapped write and unused producer codes must change nothing
      for (i = 0; i < 6; i = i + 1)
         ahb(1'b1, {2'b00, rows[i].idx, 2'b00}, ~rows[i].val);
      ahb(1'b1, 16'h0100, 32'hffff_ffff);
      upd(3'h6, 32'h1357_2468);
      upd(3'h7, 32'h2468_1357);
      for (i = 0; i < 6; i = i + 1) begin
         ahb(1'b0, {2'b00, rows[i].idx, 2'b00}, 32'h0);
         check("word after ignored write", rd, rows[i].val);
      end
      ahb(1'b0, 16'h0100, 32'h0);
      check("unmapped read", rd, 32'h0000_0000);
      // hold mode keeps the host copy; a snapshot then moves all words at once
      ahb(1'b1, 16'h1400, 32'h0000_0000);
      upd(`FMR_SEL_I_ALPHA, 32'h1111_2222);
      ahb(1'b0, {2'b00, rows[4].idx, 2'b00}, 32'h0);
      check("held word", rd, rows[4].val);
      ahb(1'b0, 16'h1408, 32'h0);
      check("update count", rd, 32'h0000_0007);
      ahb(1'b1, 16'h1400, 32'h0000_0002);
      ahb(1'b0, {2'b00, rows[4].idx, 2'b00}, 32'h0);
      check("snapshot word", rd, 32'h1111_2222);
      ahb(1'b0, 16'h1404, 32'h0);
      check("status", rd, 32'h0000_002f);
      ahb(1'b1, 16'h1400, 32'h0000_0005);
      ahb(1'b0, 16'h1408, 32'h0);
      check("cleared count", rd, 32'h0000_0000);
      ahb(1'b0, 16'h1400, 32'h0);
      check("control", rd, 32'h0000_0001);
      do_reset();
      read_zeros();
      conclude();
   end
endmodule
